// *** rfe_ctrl_regs.sv ***
// Front-end control and status registers: receive filter, gain, transmit,
// receive port and auxiliary clock settings, die revision.
// Assumes a serial port engine delivers byte writes and reads on one clock.
//
// Notes on behaviour
// - Wideband filter bit selects high cutoff and caps receive gain at 30 dB.
// - Writing one to offset bit starts correction; reads zero once done.
// - Calibration busy bit is high during a roughly 500 us calibration; read-only.
// - Calibrate after reset, then every 2 s unless disabled; zero write restarts.
// - Five-bit gain code in 2 dB steps, lowest at 0x00, reset 0x00.
// - Gain field reads the applied gain, pin derived when register mode is off.
// - Gain source bit picks register when high, pins and boost when low.
// - Boost status bit is read-only and shows the boost pin level.
// - Boost polarity bit inverts the boost value mapped from the pins.
// - Codes 0x00-0x11 give 2*code-6 dB, split continuous and switched.
// - Codes 0x12-0x15 give 30-36 dB, saturating at 30 dB when wideband.
// - Transmit format bit selects twos complement when high, binary when low.
// - Transmit edge bit captures on falling clock edge when high.
// - Interpolation field: 0x1 2x low-pass, 0x2 bypass, 0x5 2x band-pass.
// - Transmit reads at oscillator times multiplier, half that when interpolating.
// - Receive format bit selects twos complement output when high.
// - Receive edge bit aligns output data to falling receive clock when high.
// - Receive three-state bit floats the receive data pins while high.
// - Disable bits 4 and 5 hold the first and second clock outputs low.
// - First clock output runs at oscillator rate when selected, else times multiplier.
// - Second clock output runs at oscillator quarter when selected, else half.
// - Multiplier field codes 00 to 11 give factors 1, 2, 4, 8.
`timescale 1ns/1ps

module rfe_ctrl_regs
    import rfe_pkg::*;
#(
    parameter int CAL_LEN = CAL_CYCLES,
    parameter int CAL_INTERVAL = CAL_PERIOD_CYCLES,
    parameter int OFS_LEN = OFS_CORR_CYCLES
)
(
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [3:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    input wire logic [1:0] PLL_MULT_SEL,
    input wire logic [2:0] GAIN_CODE_PINS,
    input wire logic RX_GAIN_BOOST_PIN_I,
    output logic RX_GAIN_BOOST_PIN_O,
    output logic RX_GAIN_BOOST_PIN_OE,
    output rfe_gain_t RX_GAIN,
    output logic RX_LPF_BYPASS,
    output logic RX_ONE_POLE_EN,
    output logic RX_LPF_WIDEBAND,
    output logic RX_FAST_ADC,
    output logic RX_HPF_BYPASS,
    output logic [7:0] RX_TUNING_TARGET,
    output logic RX_OFS_CORR_ACTIVE,
    output logic RX_LPF_CAL_ACTIVE,
    output logic TX_TWOS_COMP,
    output logic TX_SAMPLE_FALLING,
    output logic TX_INTERP_2X,
    output logic TX_INTERP_BANDPASS,
    output logic TX_WORD_READ_EN,
    output logic RX_TWOS_COMP,
    output logic RX_OUTPUT_FALLING,
    output logic RX_DATA_OE,
    output logic AUX_CLK_A,
    output logic AUX_CLK_B
);

    // -----
    // Reset release and pin synchronisers
    // -----
    logic [1:0] rst_sync_ff;
    logic rst_n;
    logic [2:0] pins_meta_ff;
    logic [2:0] pins_ff;
    logic boost_meta_ff;
    logic boost_ff;

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
            rst_sync_ff <= 2'h0;
        else
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
    assign rst_n = rst_sync_ff[1];

    // Gain pins are asynchronous to this clock
    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pins_meta_ff <= 3'h0;
            pins_ff <= 3'h0;
            boost_meta_ff <= 1'b0;
            boost_ff <= 1'b0;
        end
        else
        begin
            pins_meta_ff <= GAIN_CODE_PINS;
            pins_ff <= pins_meta_ff;
            boost_meta_ff <= RX_GAIN_BOOST_PIN_I;
            boost_ff <= boost_meta_ff;
        end
    end

    // -----
    // Plain register storage
    // -----
    logic [7:0] filt_ff;
    logic [7:0] target_ff;
    logic [7:0] gain_ctl_ff;
    logic [7:0] tx_ff;
    logic [7:0] rx_output_clock_ff;
    logic wr_filt;

    assign wr_filt = REG_WR && (REG_ADDR == ADDR_RX_FILTER_SEL);

    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            filt_ff <= RST_RX_FILTER_SEL;
            target_ff <= RST_TUNING_TARGET;
            gain_ctl_ff <= RST_GAIN_ADJUST;
            tx_ff <= RST_TX_SETTINGS;
            rx_output_clock_ff <= RST_RX_CLK_SETTINGS;
        end
        else if (REG_WR)
        begin
            unique case (REG_ADDR)
                ADDR_RX_FILTER_SEL: filt_ff <= REG_WDATA;
                ADDR_TUNING_TARGET: target_ff <= REG_WDATA;
                ADDR_GAIN_ADJUST: gain_ctl_ff <= REG_WDATA;
                ADDR_TX_SETTINGS: tx_ff <= REG_WDATA & TX_SETTINGS_MASK;
                ADDR_RX_CLK_SETTINGS: rx_output_clock_ff <= REG_WDATA & RX_CLK_SETTINGS_MASK;
                default: ;
            endcase
        end
    end

    // -----
    // Offset correction
    // -----
    logic ofs_busy_ff;
    logic [15:0] ofs_cnt_ff;
    logic ofs_start;

    assign ofs_start = wr_filt && REG_WDATA[B_OFS_CORR];

    // A new start wins over the finishing count
    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ofs_busy_ff <= 1'b0;
            ofs_cnt_ff <= 16'h0000;
        end
        else if (ofs_start)
        begin
            ofs_busy_ff <= 1'b1;
            ofs_cnt_ff <= 16'(OFS_LEN - 1);
        end
        else if (ofs_busy_ff)
        begin
            if (ofs_cnt_ff == 16'h0000)
                ofs_busy_ff <= 1'b0;
            else
                ofs_cnt_ff <= ofs_cnt_ff - 16'h0001;
        end
    end

    // -----
    // Filter calibration, at reset and in the background
    // -----
    logic cal_busy_ff;
    logic [31:0] cal_cnt_ff;
    logic [31:0] period_cnt_ff;
    logic cal_pending_ff;
    logic cal_kick;
    logic period_due;

    assign cal_kick = wr_filt && !REG_WDATA[B_CAL_DISABLE];
    assign period_due = !filt_ff[B_CAL_DISABLE] && (period_cnt_ff == 32'(CAL_INTERVAL - 1));

    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
            cal_pending_ff <= 1'b1;
        else
            cal_pending_ff <= 1'b0;
    end

    // Interval counts from each kick; held clear while disabled
    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
            period_cnt_ff <= 32'h0000_0000;
        else if (cal_kick || period_due || filt_ff[B_CAL_DISABLE])
            period_cnt_ff <= 32'h0000_0000;
        else
            period_cnt_ff <= period_cnt_ff + 32'h0000_0001;
    end

    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cal_busy_ff <= 1'b0;
            cal_cnt_ff <= 32'h0000_0000;
        end
        else if (cal_kick || period_due || cal_pending_ff)
        begin
            cal_busy_ff <= 1'b1;
            cal_cnt_ff <= 32'(CAL_LEN - 1);
        end
        else if (cal_busy_ff)
        begin
            if (cal_cnt_ff == 32'h0000_0000)
                cal_busy_ff <= 1'b0;
            else
                cal_cnt_ff <= cal_cnt_ff - 32'h0000_0001;
        end
    end

    // -----
    // Gain source, mapping and split
    // -----
    // Pin mode: 8 dB steps through pin 6, pin 7 repeats pin 6; upper codes lean on the external boost stage
    function automatic rfe_pin_gain_t pin_map(input logic [2:0] p);
        rfe_pin_gain_t r;
        r = '0;
        unique case (p)
            3'h0: r = '{boost: 1'b0, code: 5'h03};
            3'h1: r = '{boost: 1'b0, code: 5'h07};
            3'h2: r = '{boost: 1'b0, code: 5'h0B};
            3'h3: r = '{boost: 1'b0, code: 5'h0F};
            3'h4: r = '{boost: 1'b1, code: 5'h07};
            3'h5: r = '{boost: 1'b1, code: 5'h0B};
            3'h6: r = '{boost: 1'b1, code: 5'h0F};
            3'h7: r = '{boost: 1'b1, code: 5'h0F};
        endcase
        return r;
    endfunction

    function automatic rfe_gain_t gain_split(input logic [4:0] c_in, input logic wide);
        rfe_gain_t g;
        logic [4:0] c;
        c = (c_in > GAIN_CODE_MAX) ? GAIN_CODE_MAX : c_in;
        if (wide && c > GAIN_CODE_WIDE_MAX)
            c = GAIN_CODE_WIDE_MAX;
        g.code = c;
        g.total_db = $signed({2'b00, c, 1'b0}) - GAIN_OFFSET_DB;
        if (c < GAIN_CODE_CONT_FIRST)
            g.cont_db = 8'sh00;
        else if (c <= GAIN_CODE_TOP_LINEAR)
            g.cont_db = CONT_STEP_DB * $signed({3'b000, c / 5'h03}) - CONT_STEP_DB;
        else if (wide)
            g.cont_db = CONT_TOP_WIDE_DB;
        else
            g.cont_db = CONT_TOP_NARROW_DB;
        g.switched_db = g.total_db - g.cont_db;
        return g;
    endfunction

    rfe_pin_gain_t pin_gain;
    logic [4:0] src_code;
    rfe_gain_t nxt_gain;
    logic gain_from_reg;

    assign gain_from_reg = gain_ctl_ff[B_GAIN_FROM_REG];
    assign pin_gain = pin_map(pins_ff);
    assign src_code = gain_from_reg ? gain_ctl_ff[4:0] : pin_gain.code;
    assign nxt_gain = gain_split(src_code, filt_ff[B_WIDEBAND]);

    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            RX_GAIN <= gain_split(RST_GAIN_ADJUST[4:0], RST_RX_FILTER_SEL[B_WIDEBAND]);
            RX_GAIN_BOOST_PIN_O <= 1'b0;
            RX_GAIN_BOOST_PIN_OE <= 1'b0;
        end
        else
        begin
            RX_GAIN <= nxt_gain;
            RX_GAIN_BOOST_PIN_O <= pin_gain.boost ^ gain_ctl_ff[B_BOOST_INVERT];
            RX_GAIN_BOOST_PIN_OE <= !gain_from_reg;
        end
    end

    // -----
    // Transmit word rate and auxiliary clocks
    // -----
    logic interp_bypass;
    logic [5:0] tx_period;
    logic [5:0] clka_period;
    logic [5:0] clkb_period;
    logic clka_tick;
    logic clkb_tick;
    logic clka_ff;
    logic clkb_ff;

    assign interp_bypass = (tx_ff[7:4] == INTERP_BYPASS);
    // Factor 1, 2, 4, 8 as a right shift of the period
    assign tx_period = interp_bypass ? (OSC_PERIOD >> PLL_MULT_SEL)
                                     : (OSC_HALF_RATE_PERIOD >> PLL_MULT_SEL);
    assign clka_period = rx_output_clock_ff[B_CLKA_OSC] ? OSC_HALF_PERIOD
                                              : (OSC_HALF_PERIOD >> PLL_MULT_SEL);
    assign clkb_period = rx_output_clock_ff[B_CLKB_QUARTER] ? OSC_HALF_RATE_PERIOD : OSC_PERIOD;

    rfe_rate_div u_tx_rate (
        .clk(CLK_SYS),
        .rst_n(rst_n),
        .period(tx_period),
        .tick(TX_WORD_READ_EN)
    );

    rfe_rate_div u_clka_rate (
        .clk(CLK_SYS),
        .rst_n(rst_n),
        .period(clka_period),
        .tick(clka_tick)
    );

    rfe_rate_div u_clkb_rate (
        .clk(CLK_SYS),
        .rst_n(rst_n),
        .period(clkb_period),
        .tick(clkb_tick)
    );

    // Disabled outputs sit low rather than freezing mid-level
    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clka_ff <= 1'b0;
            clkb_ff <= 1'b0;
        end
        else
        begin
            clka_ff <= rx_output_clock_ff[B_CLKA_DIS] ? 1'b0 : clka_ff ^ clka_tick;
            clkb_ff <= rx_output_clock_ff[B_CLKB_DIS] ? 1'b0 : clkb_ff ^ clkb_tick;
        end
    end
    assign AUX_CLK_A = clka_ff;
    assign AUX_CLK_B = clkb_ff;

    // -----
    // Steering outputs
    // -----
    assign RX_LPF_BYPASS = filt_ff[B_LPF_BYPASS];
    assign RX_ONE_POLE_EN = filt_ff[B_ONE_POLE];
    assign RX_LPF_WIDEBAND = filt_ff[B_WIDEBAND];
    assign RX_FAST_ADC = filt_ff[B_FAST_ADC];
    assign RX_HPF_BYPASS = filt_ff[B_HPF_BYPASS];
    assign RX_TUNING_TARGET = target_ff;
    assign RX_OFS_CORR_ACTIVE = ofs_busy_ff;
    assign RX_LPF_CAL_ACTIVE = cal_busy_ff;
    assign TX_TWOS_COMP = tx_ff[B_TX_TWOS];
    assign TX_SAMPLE_FALLING = tx_ff[B_TX_FALLING];
    assign TX_INTERP_2X = !interp_bypass;
    assign TX_INTERP_BANDPASS = (tx_ff[7:4] == INTERP_2X_BPF);
    assign RX_TWOS_COMP = rx_output_clock_ff[B_RX_TWOS];
    assign RX_OUTPUT_FALLING = rx_output_clock_ff[B_RX_FALLING];
    assign RX_DATA_OE = !rx_output_clock_ff[B_RX_TRISTATE];

    // -----
    // Read path
    // -----
    logic [7:0] nxt_rdata;

    always_comb
    begin
        nxt_rdata = 8'h00;
        unique case (REG_ADDR)
            ADDR_RX_FILTER_SEL:
            begin
                nxt_rdata = filt_ff;
                nxt_rdata[B_OFS_CORR] = ofs_busy_ff;
                nxt_rdata[B_CAL_BUSY] = cal_busy_ff;
            end
            ADDR_TUNING_TARGET: nxt_rdata = target_ff;
            ADDR_GAIN_ADJUST:
            begin
                nxt_rdata = gain_ctl_ff;
                nxt_rdata[4:0] = RX_GAIN.code;
                nxt_rdata[B_BOOST_LEVEL] = boost_ff;
            end
            ADDR_TX_SETTINGS: nxt_rdata = tx_ff;
            ADDR_RX_CLK_SETTINGS: nxt_rdata = rx_output_clock_ff;
            ADDR_DIE_REVISION: nxt_rdata = DIE_REVISION_VALUE;
            default: nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            REG_RDATA <= 8'h00;
            REG_RVALID <= 1'b0;
        end
        else
        begin
            REG_RVALID <= REG_RD;
            if (REG_RD)
                REG_RDATA <= nxt_rdata;
        end
    end

endmodule // rfe_ctrl_regs

// *** rfe_ctrl_regs_props.sv ***
// Concurrent checks on the front-end control register block.
// Assumes it is bound into rfe_ctrl_regs and sees only that module's ports.
`timescale 1ns/1ps

module rfe_ctrl_regs_props
    import rfe_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic REG_WR,
    input wire logic [3:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic RX_GAIN_BOOST_PIN_OE,
    input wire rfe_gain_t RX_GAIN,
    input wire logic RX_LPF_WIDEBAND,
    input wire logic RX_OFS_CORR_ACTIVE,
    input wire logic RX_LPF_CAL_ACTIVE,
    input wire logic TX_WORD_READ_EN,
    input wire logic RX_DATA_OE,
    input wire logic AUX_CLK_A
);
    // -----
    // Properties
    // -----
    // Gain lags the filter bit one cycle, so only settled wideband is judged
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);
    a_wide_gain_cap: assert property (RX_LPF_WIDEBAND && $past(RX_LPF_WIDEBAND)
        |-> RX_GAIN.total_db <= 8'sh1E) else $error("wideband gain above cap");
    a_gain_split_sum: assert property (RX_GAIN.total_db == RX_GAIN.cont_db +
        RX_GAIN.switched_db) else $error("gain stages do not sum");
    a_gain_step_size: assert property (RX_GAIN.code <= 5'h11 |->
        int'(RX_GAIN.total_db) == 2 * int'(RX_GAIN.code) - 6) else $error("gain step wrong");
    a_ofs_corr_start: assert property (REG_WR && REG_ADDR == ADDR_RX_FILTER_SEL
        && REG_WDATA[B_OFS_CORR] |=> RX_OFS_CORR_ACTIVE) else $error("offset not started");
    a_cal_busy_run: assert property ($rose(RX_LPF_CAL_ACTIVE) |->
        RX_LPF_CAL_ACTIVE[*8]) else $error("calibration ended early");
    a_rx_port_float: assert property (REG_WR && REG_ADDR == ADDR_RX_CLK_SETTINGS |=>
        RX_DATA_OE == !$past(REG_WDATA[B_RX_TRISTATE])) else $error("rx port enable wrong");
    a_aux_a_off: assert property (REG_WR && REG_ADDR == ADDR_RX_CLK_SETTINGS
        && REG_WDATA[B_CLKA_DIS] |=> ##1 !AUX_CLK_A) else $error("aux clock a not held");
    a_boost_oe_src: assert property (REG_WR && REG_ADDR == ADDR_GAIN_ADJUST |=> ##1
        RX_GAIN_BOOST_PIN_OE == !$past(REG_WDATA[B_GAIN_FROM_REG], 2))
        else $error("boost enable wrong");
    a_tx_read_pulse: assert property (TX_WORD_READ_EN |=> !TX_WORD_READ_EN)
        else $error("word read pulse too long");
endmodule // rfe_ctrl_regs_props

bind rfe_ctrl_regs rfe_ctrl_regs_props i_rfe_ctrl_regs_props (.CLK_SYS, .RST_N, .REG_WR,
    .REG_ADDR, .REG_WDATA, .RX_GAIN_BOOST_PIN_OE, .RX_GAIN, .RX_LPF_WIDEBAND,
    .RX_OFS_CORR_ACTIVE, .RX_LPF_CAL_ACTIVE, .TX_WORD_READ_EN, .RX_DATA_OE, .AUX_CLK_A);

// *** rfe_ctrl_regs_tb_top.sv ***
// Self-checking bench for the front-end control registers.
// Assumes shortened calibration and offset counts; the bench plays the boost pin.
`timescale 1ns/1ps

module rfe_ctrl_regs_tb_top
    import rfe_pkg::*;
;
    // -----
    // Signals and instance
    // -----
    localparam int CL = 20;
    localparam int CI = 200;
    localparam int OL = 4;
    logic CLK_SYS = 1'b0;
    logic RST_N = 1'b0;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [3:0] REG_ADDR = 4'h0;
    logic [7:0] REG_WDATA = 8'h00;
    logic [1:0] PLL_MULT_SEL = 2'h0;
    logic [2:0] GAIN_CODE_PINS = 3'h0;
    logic bst_tb = 1'b0;
    logic [7:0] REG_RDATA, RX_TUNING_TARGET;
    logic REG_RVALID, RX_GAIN_BOOST_PIN_O, RX_GAIN_BOOST_PIN_OE, RX_LPF_BYPASS, RX_ONE_POLE_EN;
    logic RX_LPF_WIDEBAND, RX_FAST_ADC, RX_HPF_BYPASS, RX_OFS_CORR_ACTIVE, RX_LPF_CAL_ACTIVE;
    logic TX_TWOS_COMP, TX_SAMPLE_FALLING, TX_INTERP_2X, TX_INTERP_BANDPASS, TX_WORD_READ_EN;
    logic RX_TWOS_COMP, RX_OUTPUT_FALLING, RX_DATA_OE, AUX_CLK_A, AUX_CLK_B;
    rfe_gain_t RX_GAIN;
    int miscompares = 0;
    int cmp_count = 0;
    int n_cal = 0;
    int nt, na, nb;
    logic [4:0] gc [6] = '{5'h00, 5'h05, 5'h11, 5'h12, 5'h15, 5'h1F};
    logic [3:0] ic [3] = '{INTERP_2X_LPF, INTERP_BYPASS, INTERP_2X_BPF};
    // Shared boost wire: device drives it only in pin mode
    wire logic RX_GAIN_BOOST_PIN_I = RX_GAIN_BOOST_PIN_OE ? RX_GAIN_BOOST_PIN_O : bst_tb;

    rfe_ctrl_regs #(.CAL_LEN(CL), .CAL_INTERVAL(CI), .OFS_LEN(OL)) i_rfe_ctrl_regs (
        .CLK_SYS, .RST_N, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA, .REG_RDATA, .REG_RVALID,
        .PLL_MULT_SEL, .GAIN_CODE_PINS, .RX_GAIN_BOOST_PIN_I, .RX_GAIN_BOOST_PIN_O,
        .RX_GAIN_BOOST_PIN_OE, .RX_GAIN, .RX_LPF_BYPASS, .RX_ONE_POLE_EN, .RX_LPF_WIDEBAND,
        .RX_FAST_ADC, .RX_HPF_BYPASS, .RX_TUNING_TARGET, .RX_OFS_CORR_ACTIVE,
        .RX_LPF_CAL_ACTIVE, .TX_TWOS_COMP, .TX_SAMPLE_FALLING, .TX_INTERP_2X,
        .TX_INTERP_BANDPASS, .TX_WORD_READ_EN, .RX_TWOS_COMP, .RX_OUTPUT_FALLING,
        .RX_DATA_OE, .AUX_CLK_A, .AUX_CLK_B);

    initial forever #2 CLK_SYS = ~CLK_SYS;
    always @(posedge RX_LPF_CAL_ACTIVE) n_cal++;

    // -----
    // Tasks
    // -----
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge CLK_SYS);
        #1;
    endtask
    task automatic rst();
        RST_N <= 1'b0;
        tick(2);
        RST_N <= 1'b1;
        tick(6);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLK_SYS);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CLK_SYS);
        REG_WR <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge CLK_SYS);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLK_SYS);
        REG_RD <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), REG_RDATA & m, e);
    endtask
    // Counts read pulses and clock toggles over 64 settled cycles
    task automatic meas();
        logic pa, pb;
        nt = 0;
        na = 0;
        nb = 0;
        tick(40);
        pa = AUX_CLK_A;
        pb = AUX_CLK_B;
        repeat (64)
        begin
            tick(1);
            nt += TX_WORD_READ_EN;
            na += AUX_CLK_A ^ pa;
            nb += AUX_CLK_B ^ pb;
            pa = AUX_CLK_A;
            pb = AUX_CLK_B;
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // -----
    // Tests
    // -----
    initial
    begin
        int c, ct;
        rst();
        chk("cal at reset", RX_LPF_CAL_ACTIVE, 1);
        tick(CL + 4);
        rdc(ADDR_RX_FILTER_SEL, 8'hFF, RST_RX_FILTER_SEL);
        rdc(ADDR_TUNING_TARGET, 8'hFF, RST_TUNING_TARGET);
        rdc(ADDR_GAIN_ADJUST, 8'hFF, 8'h03);
        rdc(ADDR_TX_SETTINGS, 8'hFF, RST_TX_SETTINGS);
        rdc(ADDR_RX_CLK_SETTINGS, 8'hFF, RST_RX_CLK_SETTINGS);
        wr(ADDR_DIE_REVISION, 8'hFF);
        rdc(ADDR_DIE_REVISION, 8'hFF, DIE_REVISION_VALUE);
        wr(4'h3, 8'hFF);
        rdc(4'h3, 8'hFF, 8'h00);
        $display("reset and map test done");
        bst_tb <= 1'b1;
        for (int w = 0; w < 2; w++)
        begin
            wr(ADDR_RX_FILTER_SEL, w ? 8'h04 : 8'h00);
            chk("wideband", RX_LPF_WIDEBAND, 8'(w));
            foreach (gc[i])
            begin
                c = (gc[i] > 21) ? 21 : gc[i];
                if (w && c > 18) c = 18;
                wr(ADDR_GAIN_ADJUST, {3'h1, gc[i]});
                tick(3);
                ct = (c < 6) ? 0 : (c >= 18) ? (w ? 24 : 30) : 6 * (c / 3 - 1);
                chk("total", RX_GAIN.total_db, 8'(2 * c - 6));
                chk("cont", RX_GAIN.cont_db, 8'(ct));
                chk("switched", RX_GAIN.switched_db, 8'(2 * c - 6 - ct));
                rdc(ADDR_GAIN_ADJUST, 8'hFF, 8'h60 | 8'(c));
            end
        end
        GAIN_CODE_PINS <= 3'h5;
        wr(ADDR_GAIN_ADJUST, 8'h40);
        tick(5);
        chk("boost out", {RX_GAIN_BOOST_PIN_OE, RX_GAIN_BOOST_PIN_O}, 3);
        rdc(ADDR_GAIN_ADJUST, 8'hFF, 8'h4B);
        wr(ADDR_GAIN_ADJUST, 8'h80);
        tick(5);
        chk("boost inv", RX_GAIN_BOOST_PIN_O, 0);
        rdc(ADDR_GAIN_ADJUST, 8'hFF, 8'h8B);
        $display("gain test done");
        wr(ADDR_TX_SETTINGS, 8'hFF);
        rdc(ADDR_TX_SETTINGS, 8'hFF, TX_SETTINGS_MASK);
        chk("tx fmt", {TX_TWOS_COMP, TX_SAMPLE_FALLING}, 3);
        wr(ADDR_RX_CLK_SETTINGS, 8'hFF);
        rdc(ADDR_RX_CLK_SETTINGS, 8'hFF, RX_CLK_SETTINGS_MASK);
        chk("rx fmt", {RX_TWOS_COMP, RX_OUTPUT_FALLING, RX_DATA_OE}, 6);
        meas();
        chk("aux off", 8'(na + nb + AUX_CLK_A + AUX_CLK_B), 0);
        for (int s = 0; s < 4; s++)
        begin
            PLL_MULT_SEL <= 2'(s);
            foreach (ic[i])
            begin
                wr(ADDR_TX_SETTINGS, {ic[i], 4'h0});
                wr(ADDR_RX_CLK_SETTINGS, {i[0], i[1], 6'h00});
                meas();
                chk("interp", {TX_INTERP_2X, TX_INTERP_BANDPASS, TX_TWOS_COMP},
                    {5'h0, ic[i] != INTERP_BYPASS, ic[i] == INTERP_2X_BPF, 1'b0});
                chk("tx rate", 8'(nt),
                    8'(64 / ((ic[i] == INTERP_BYPASS ? 16 : 32) >> s)));
                chk("aux a", 8'(na), 8'(i[1] ? 8 : 64 / (8 >> s)));
                chk("aux b", 8'(nb), 8'(i[0] ? 2 : 4));
            end
        end
        $display("transmit and clock test done");
        wr(ADDR_TUNING_TARGET, 8'h5A);
        chk("target", RX_TUNING_TARGET, 8'h5A);
        wr(ADDR_RX_FILTER_SEL, 8'h9B);
        chk("filt out", {RX_HPF_BYPASS, RX_FAST_ADC, RX_LPF_WIDEBAND,
            RX_ONE_POLE_EN, RX_LPF_BYPASS}, 8'h1B);
        tick(CL + 4);
        n_cal = 0;
        tick(2 * CI);
        chk("cal off", 8'(n_cal), 0);
        wr(ADDR_RX_FILTER_SEL, 8'hE0);
        rdc(ADDR_RX_FILTER_SEL, 8'hE0, 8'hA0);
        tick(OL + 2);
        rdc(ADDR_RX_FILTER_SEL, 8'hE0, 8'h80);
        wr(ADDR_RX_FILTER_SEL, 8'h00);
        tick(2);
        rdc(ADDR_RX_FILTER_SEL, 8'h40, 8'h40);
        tick(CL + 2);
        rdc(ADDR_RX_FILTER_SEL, 8'h40, 8'h00);
        n_cal = 0;
        tick(CI + CL);
        chk("cal periodic", 8'(n_cal), 1);
        $display("calibration test done");
        rst();
        rdc(ADDR_TX_SETTINGS, 8'hFF, RST_TX_SETTINGS);
        $display("second reset test done");
        finish_test();
    end

    initial
    begin
        repeat (20000) @(posedge CLK_SYS);
        miscompares++;
        finish_test();
    end
endmodule // rfe_ctrl_regs_tb_top

// *** rfe_pkg.sv ***
// Package for the receive/transmit front-end control registers.
// Assumes CLK_SYS runs at sixteen times the reference oscillator rate.
package rfe_pkg;

    // -----
    // Register offsets
    // -----
    localparam logic [3:0] ADDR_RX_FILTER_SEL = 4'h4;
    localparam logic [3:0] ADDR_TUNING_TARGET = 4'h5;
    localparam logic [3:0] ADDR_GAIN_ADJUST = 4'h6;
    localparam logic [3:0] ADDR_TX_SETTINGS = 4'h7;
    localparam logic [3:0] ADDR_RX_CLK_SETTINGS = 4'h8;
    localparam logic [3:0] ADDR_DIE_REVISION = 4'hF;

    // -----
    // Reset values
    // -----
    localparam logic [7:0] RST_RX_FILTER_SEL = 8'h01;
    localparam logic [7:0] RST_TUNING_TARGET = 8'h80;
    localparam logic [7:0] RST_GAIN_ADJUST = 8'h00;
    localparam logic [7:0] RST_TX_SETTINGS = 8'h10;
    localparam logic [7:0] RST_RX_CLK_SETTINGS = 8'h00;
    // Arbitrary value, not tied to any real part
    localparam logic [7:0] DIE_REVISION_VALUE = 8'h03;

    // -----
    // Field positions
    // -----
    localparam int B_LPF_BYPASS = 0;
    localparam int B_ONE_POLE = 1;
    localparam int B_WIDEBAND = 2;
    localparam int B_FAST_ADC = 3;
    localparam int B_HPF_BYPASS = 4;
    localparam int B_OFS_CORR = 5;
    localparam int B_CAL_BUSY = 6;
    localparam int B_CAL_DISABLE = 7;
    localparam int B_GAIN_FROM_REG = 5;
    localparam int B_BOOST_LEVEL = 6;
    localparam int B_BOOST_INVERT = 7;
    localparam int B_TX_TWOS = 0;
    localparam int B_TX_FALLING = 1;
    localparam int B_RX_TWOS = 0;
    localparam int B_RX_FALLING = 1;
    localparam int B_RX_TRISTATE = 3;
    localparam int B_CLKA_DIS = 4;
    localparam int B_CLKB_DIS = 5;
    localparam int B_CLKA_OSC = 6;
    localparam int B_CLKB_QUARTER = 7;
    localparam logic [7:0] TX_SETTINGS_MASK = 8'hF3;
    localparam logic [7:0] RX_CLK_SETTINGS_MASK = 8'hFB;

    // -----
    // Interpolation codes and gain limits
    // -----
    localparam logic [3:0] INTERP_2X_LPF = 4'h1;
    localparam logic [3:0] INTERP_BYPASS = 4'h2;
    localparam logic [3:0] INTERP_2X_BPF = 4'h5;
    localparam logic [4:0] GAIN_CODE_TOP_LINEAR = 5'h11;
    localparam logic [4:0] GAIN_CODE_WIDE_MAX = 5'h12;
    localparam logic [4:0] GAIN_CODE_MAX = 5'h15;
    localparam logic [4:0] GAIN_CODE_CONT_FIRST = 5'h03;
    localparam logic signed [7:0] GAIN_OFFSET_DB = 8'sh06;
    localparam logic signed [7:0] CONT_STEP_DB = 8'sh06;
    localparam logic signed [7:0] CONT_TOP_NARROW_DB = 8'sh1E;
    localparam logic signed [7:0] CONT_TOP_WIDE_DB = 8'sh18;

    // -----
    // Timing
    // -----
    localparam int CLK_MHZ = 250;
    localparam int CAL_TIME_US = 500;
    localparam int CAL_PERIOD_S = 2;
    localparam int CAL_CYCLES = CAL_TIME_US * CLK_MHZ;
    localparam int CAL_PERIOD_CYCLES = CAL_PERIOD_S * CLK_MHZ * 1000000;
    localparam int OFS_CORR_CYCLES = 64;
    // Rate divider periods in CLK_SYS cycles, before the multiplier shift
    localparam logic [5:0] OSC_PERIOD = 6'h10;
    localparam logic [5:0] OSC_HALF_RATE_PERIOD = 6'h20;
    localparam logic [5:0] OSC_HALF_PERIOD = 6'h08;

    // -----
    // Carrier types
    // -----
    typedef struct packed {
        logic [4:0] code;
        logic signed [7:0] total_db;
        logic signed [7:0] cont_db;
        logic signed [7:0] switched_db;
    } rfe_gain_t;

    typedef struct packed {
        logic boost;
        logic [4:0] code;
    } rfe_pin_gain_t;

endpackage

// *** rfe_rate_div.sv ***
// Programmable rate divider giving a one-cycle enable pulse.
// Assumes the period input is at least one and comes from the same clock.
`timescale 1ns/1ps

module rfe_rate_div
    import rfe_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [5:0] period,
    output logic tick
);

    logic [5:0] cnt_ff;
    logic [5:0] nxt_cnt;
    logic wrap;

    // Wrap also when the period shrank below the count
    assign wrap = (cnt_ff >= (period - 6'h01));

    always_comb
    begin
        nxt_cnt = wrap ? 6'h00 : cnt_ff + 6'h01;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_ff <= 6'h00;
        else
            cnt_ff <= nxt_cnt;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            tick <= 1'b0;
        else
            tick <= wrap;
    end

endmodule // rfe_rate_div
